// ---- rtl/fst_pkg.sv ----
// constants shared by the flash status host controller
package fst_pkg;
    localparam int unsigned CLK_PERIOD_NS  = 100;
    localparam int unsigned WP_MIN_NS      = 60;
    localparam int unsigned WPH_MIN_NS     = 40;
    localparam int unsigned OEPS_MIN_NS    = 40;
    localparam int unsigned OE_ACC_MAX_NS  = 60;
    localparam int unsigned CPH_MIN_NS     = 200;
    localparam int unsigned RBSY_TYP_US    = 45;
    localparam int unsigned OP_MAX_MS      = 30;
    localparam int unsigned WP_CYC   = (WP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WPH_CYC  = (WPH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned OEPS_CYC = (OEPS_MIN_NS + OE_ACC_MAX_NS + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
    localparam int unsigned CPH_CYC  = (CPH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RBSY_CYC = (RBSY_TYP_US * 1000 + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
    localparam int unsigned OP_MAX_CYC = (OP_MAX_MS * 1000000) / CLK_PERIOD_NS;
    localparam int unsigned TMR_W    = 12;
    // status word field positions
    localparam int unsigned ST_READY_BIT = 7;
    localparam int unsigned ST_ECC_BIT   = 6;
    localparam int unsigned ST_ERASE_BIT = 5;
    localparam int unsigned ST_PROG_BIT  = 4;
    localparam logic [7:0]  ST_RSVD_MASK = 8'hF0;
    localparam logic [7:0]  STATUS_RST   = 8'h00;
    // command codes: values arbitrary, set per device
    localparam logic [7:0]  CMD_STATUS_DEF = 8'h5A;
    localparam logic [7:0]  CMD_CLEAR_DEF  = 8'hA5;
    localparam logic [7:0]  CMD_READ_DEF   = 8'h3C;
    localparam logic [11:0] SECTOR_BYTES   = 12'h840;
    typedef enum logic [3:0] {
        FST_IDLE   = 4'h0,
        FST_CMD    = 4'h1,
        FST_WE_LO  = 4'h3,
        FST_WE_HI  = 4'h2,
        FST_OE_LO  = 4'h6,
        FST_SAMPLE = 4'h7,
        FST_GAP    = 4'h5,
        FST_DECIDE = 4'h4,
        FST_RBSY   = 4'hC,
        FST_END    = 4'hD
    } fst_state_t;
    typedef enum logic [1:0] {
        FST_OP_POLL  = 2'h0,
        FST_OP_CLEAR = 2'h1,
        FST_OP_READ  = 2'h2
    } fst_op_t;
endpackage

// ---- rtl/fst_timer.sv ----
// down-counting delay timer with a registered expiry flag
`timescale 1ns/1ps
`default_nettype none
module fst_timer #(
    parameter int unsigned W = 12
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output var  logic         expired_q
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    wire          at_zero = (cnt_q == '0);

    generate
        if (W < 2)
        begin : g_chk
            $error("fst_timer width too small");
        end
    endgenerate

    assign cnt_d = load ? load_val : (at_zero ? cnt_q : cnt_q - W'(1));

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            cnt_q     <= '0;
            expired_q <= 1'b1;
        end
        else
        begin
            cnt_q     <= cnt_d;
            expired_q <= (cnt_d == '0);
        end
    end
endmodule // fst_timer
`default_nettype wire

// ---- rtl/fst_host.sv ----
// host controller that polls, clears and reads the flash operation status
`timescale 1ns/1ps
`default_nettype none
//
// Function
// - trust flag bits only after ready seen
// - clear status after failure before next operation
// - reserved low nibble masked on every read
// - ready and fail: ECC if bit6, else replace
// - reread failed sector before any correction (reread_q pulses in the same cycle that ecc_fix_q or replace_q is set)
// - replacement covers one whole sector
module fst_host #(
    parameter int unsigned POLL_MAX_CYC = fst_pkg::OP_MAX_CYC,
    parameter logic [7:0]  CMD_STATUS   = fst_pkg::CMD_STATUS_DEF,
    parameter logic [7:0]  CMD_CLEAR    = fst_pkg::CMD_CLEAR_DEF,
    parameter logic [7:0]  CMD_READ     = fst_pkg::CMD_READ_DEF
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             req_valid,
    input  wire fst_pkg::fst_op_t req_op,
    output var  logic             req_ready_q,
    output var  logic             done_q,
    output var  logic [7:0]       status_q,
    output var  logic             fail_q,
    output var  logic             ecc_fix_q,
    output var  logic             replace_q,
    output var  logic [11:0]      replace_len_q,
    output var  logic             reread_q,
    output var  logic             timeout_q,
    output var  logic             op_allow_q,
    output var  logic             chip_en_n_q,
    output var  logic             out_en_n_q,
    output var  logic             write_en_n_q,
    output var  logic             command_data_strobe_n_q,
    output var  logic             serial_read_strobe_q,
    input  wire logic [7:0]       io_in,
    output var  logic [7:0]       io_out_q,
    output var  logic             io_oe_q,
    input  wire logic             ready_busy
);
    import fst_pkg::*;

    generate
        if (POLL_MAX_CYC < 4 || POLL_MAX_CYC > 32'h00FF_FFFF)
        begin : g_chk
            $error("fst_host POLL_MAX_CYC out of range");
        end
    endgenerate

    // ********************************************************
    // state and helpers
    // ********************************************************
    fst_state_t        st_q;
    fst_state_t        st_d;
    fst_op_t           op_q;
    logic [23:0]       poll_cnt_q;
    logic              tmr_load;
    logic [TMR_W-1:0]  tmr_val;
    logic              tmr_exp;

    function automatic logic [TMR_W-1:0] cyc(input int unsigned n);
        cyc = TMR_W'(n - 1);
    endfunction

    wire        take      = (st_q == FST_IDLE) && req_valid;
    wire [7:0]  io_masked = io_in & ST_RSVD_MASK;
    wire        dev_ready = io_in[ST_READY_BIT];
    wire        poll_over = (poll_cnt_q >= 24'(POLL_MAX_CYC));
    wire [7:0]  cmd_byte  = (op_q == FST_OP_CLEAR) ? CMD_CLEAR :
                            (op_q == FST_OP_READ)  ? CMD_READ  : CMD_STATUS;
    wire        flag_fail = status_q[ST_ERASE_BIT] | status_q[ST_PROG_BIT];

    fst_timer #(.W(TMR_W)) u_tmr (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .load      (tmr_load),
        .load_val  (tmr_val),
        .expired_q (tmr_exp)
    );

    // ********************************************************
    // sequencer
    // ********************************************************
    always_comb
    begin
        st_d     = st_q;
        tmr_load = 1'b0;
        tmr_val  = cyc(1);
        case (st_q)
            FST_IDLE:
                if (take)
                begin
                    st_d     = FST_CMD;
                    tmr_load = 1'b1;
                end
            FST_CMD:
                if (tmr_exp)
                begin
                    st_d     = FST_WE_LO;
                    tmr_load = 1'b1;
                    tmr_val  = cyc(WP_CYC);
                end
            FST_WE_LO:
                if (tmr_exp)
                begin
                    st_d     = FST_WE_HI;
                    tmr_load = 1'b1;
                    tmr_val  = cyc(WPH_CYC);
                end
            FST_WE_HI:
                if (tmr_exp)
                begin
                    tmr_load = 1'b1;
                    if (op_q == FST_OP_CLEAR)
                        st_d = FST_END;
                    else if (op_q == FST_OP_READ)
                    begin
                        st_d    = FST_RBSY;
                        tmr_val = cyc(RBSY_CYC);
                    end
                    else
                    begin
                        st_d    = FST_OE_LO;
                        tmr_val = cyc(OEPS_CYC);
                    end
                end
            FST_OE_LO:
                if (tmr_exp)
                    st_d = FST_SAMPLE;
            FST_SAMPLE:
                if (dev_ready)
                    st_d = FST_DECIDE;
                else
                begin
                    st_d     = FST_GAP;
                    tmr_load = 1'b1;
                    tmr_val  = cyc(CPH_CYC);
                end
            FST_GAP:
                if (poll_over)
                    st_d = FST_END;
                else if (tmr_exp)
                begin
                    st_d     = FST_OE_LO;
                    tmr_load = 1'b1;
                    tmr_val  = cyc(OEPS_CYC);
                end
            FST_DECIDE:
                st_d = FST_END;
            FST_RBSY:
                // busy interval always waited out, limit only after it
                if (tmr_exp && (ready_busy || poll_over))
                    st_d = FST_END;
            FST_END:
                st_d = FST_IDLE;
            default:
                st_d = FST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            st_q       <= FST_IDLE;
            op_q       <= FST_OP_POLL;
            poll_cnt_q <= '0;
        end
        else
        begin
            st_q       <= st_d;
            op_q       <= take ? req_op : op_q;
            poll_cnt_q <= (st_q == FST_WE_HI || st_q == FST_IDLE) ? '0 : poll_cnt_q + 24'(1);
        end
    end

    // ********************************************************
    // device pins
    // ********************************************************
    wire cmd_phase = (st_d == FST_CMD) || (st_d == FST_WE_LO) || (st_d == FST_WE_HI);
    wire rd_phase  = (st_d == FST_OE_LO) || (st_d == FST_SAMPLE);
    wire ce_act    = cmd_phase || rd_phase || (st_d == FST_RBSY);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            chip_en_n_q             <= 1'b1;
            out_en_n_q              <= 1'b1;
            write_en_n_q            <= 1'b1;
            command_data_strobe_n_q <= 1'b1;
            serial_read_strobe_q    <= 1'b0;
            io_out_q                <= 8'h00;
            io_oe_q                 <= 1'b0;
        end
        else
        begin
            chip_en_n_q             <= !ce_act;
            out_en_n_q              <= !rd_phase;
            write_en_n_q            <= (st_d != FST_WE_LO);
            command_data_strobe_n_q <= !cmd_phase;
            serial_read_strobe_q    <= 1'b0;
            io_out_q                <= cmd_phase ? cmd_byte : 8'h00;
            io_oe_q                 <= cmd_phase;
        end
    end

    // ********************************************************
    // status capture and recovery decision
    // ********************************************************
    wire dec_now    = (st_q == FST_DECIDE);
    wire want_repl  = flag_fail && !status_q[ST_ECC_BIT];
    wire clear_done = (st_q == FST_END) && (op_q == FST_OP_CLEAR);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            status_q      <= STATUS_RST;
            fail_q        <= 1'b0;
            ecc_fix_q     <= 1'b0;
            replace_q     <= 1'b0;
            replace_len_q <= 12'h000;
            reread_q      <= 1'b0;
            timeout_q     <= 1'b0;
            op_allow_q    <= 1'b1;
            done_q        <= 1'b0;
            req_ready_q   <= 1'b0;
        end
        else
        begin
            if (st_q == FST_SAMPLE && dev_ready)
                status_q <= io_masked;
            reread_q  <= dec_now && flag_fail;
            fail_q    <= dec_now ? flag_fail : fail_q;
            ecc_fix_q <= dec_now ? (flag_fail && status_q[ST_ECC_BIT]) : ecc_fix_q;
            replace_q <= dec_now ? (flag_fail && !status_q[ST_ECC_BIT]) : replace_q;
            if (dec_now)
                replace_len_q <= want_repl ? SECTOR_BYTES : 12'h000;
            if (take)
                timeout_q <= 1'b0;
            else if (st_q == FST_GAP && poll_over)
                timeout_q <= 1'b1;
            else if (st_q == FST_RBSY && tmr_exp && !ready_busy && poll_over)
                timeout_q <= 1'b1;
            if (dec_now && flag_fail)
                op_allow_q <= 1'b0;
            else if (clear_done)
                op_allow_q <= 1'b1;
            done_q      <= (st_q == FST_END);
            req_ready_q <= (st_d == FST_IDLE);
        end
    end

    // ********************************************************
    // checks
    // ********************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    mask_low_nibble_a: assert property (status_q[3:0] == 4'h0)
        else $error("reserved status bits not masked");
    decide_on_ready_a: assert property (dec_now |-> status_q[ST_READY_BIT])
        else $error("decision taken without ready");
    ecc_choice_a: assert property (
        dec_now && flag_fail && status_q[ST_ECC_BIT] |=> ecc_fix_q && !replace_q)
        else $error("ECC path not chosen");
    replace_choice_a: assert property (
        dec_now && flag_fail && !status_q[ST_ECC_BIT]
        |=> replace_q && replace_len_q == SECTOR_BYTES)
        else $error("sector replacement not chosen");
    reread_first_a: assert property (dec_now && flag_fail |=> reread_q)
        else $error("failed sector not reread");
    block_after_fail_a: assert property (
        dec_now && flag_fail |=> !op_allow_q throughout (!clear_done)[*2])
        else $error("operation allowed before clear");
    read_busy_wait_a: assert property (
        $rose(st_q == FST_RBSY) |-> (st_q == FST_RBSY)[*8])
        else $error("read busy interval cut short");
    we_pulse_a: assert property (
        $fell(write_en_n_q) |-> !chip_en_n_q && !command_data_strobe_n_q ##1 write_en_n_q)
        else $error("write pulse malformed");
    io_drive_a: assert property (io_oe_q |-> out_en_n_q)
        else $error("bus contention with device output");

    poll_ok_c:  cover property (dec_now && !flag_fail);
    ecc_c:      cover property (dec_now && flag_fail && status_q[ST_ECC_BIT]);
    replace_c:  cover property (dec_now && flag_fail && !status_q[ST_ECC_BIT]);
    clear_c:    cover property (clear_done);
endmodule // fst_host
`default_nettype wire

// ---- verif/fst_dev_model.sv ----
// behavioural flash device answering status polls, clears and read access
`timescale 1ns/1ps
`default_nettype none
module fst_dev_model
    import fst_pkg::*;
#(
    parameter int unsigned RBSY_NS = RBSY_TYP_US * 1000
) (
    input  wire logic       ce_n,
    input  wire logic       oe_n,
    input  wire logic       we_n,
    input  wire logic       command_data_strobe_n,
    input  wire logic [7:0] io_out,
    input  wire logic       io_oe,
    output var  logic [7:0] io_in,
    output var  logic       ready_busy
);
    // *********************
    // status and commands
    // *********************
    logic [2:0] flags   = 3'h0;
    realtime    busy_until = 0;
    logic [7:0] cmd_q   = 8'h00;
    logic [7:0] last_q  = 8'h00;
    initial io_in = 8'h00;
    initial ready_busy = 1'b1;
    always @(posedge we_n)
    begin
        if (!ce_n && !command_data_strobe_n && io_oe)
        begin
            cmd_q = io_out;
            if (io_out == CMD_CLEAR_DEF)
                flags = 3'h0;
            if (io_out == CMD_READ_DEF)
            begin
                ready_busy = 1'b0;
                #(RBSY_NS) ready_busy = 1'b1;
            end
        end
    end
    always @(oe_n or ce_n)
    begin
        if (!oe_n && !ce_n && cmd_q == CMD_STATUS_DEF)
        begin
            if ($realtime >= busy_until)
                last_q = {1'b1, flags, 4'h0};
            else
                last_q = {1'b0, ~flags, 4'h0};
            io_in = last_q;
        end
        else
            io_in = ~io_in; // released bus drifts
    end
endmodule // fst_dev_model
`default_nettype wire

// ---- verif/fst_host_bench.sv ----
// self-checking bench for the flash status host controller
`timescale 1ns/1ps
`default_nettype none
module fst_host_bench;
    import fst_pkg::*;
    localparam int unsigned POLL_SIM = 200;
    logic        clk_sys = 1'b0, rst_n = 1'b0, req_valid = 1'b0;
    fst_op_t     req_op = FST_OP_POLL;
    logic        req_ready_q, done_q, fail_q, ecc_fix_q, replace_q, reread_q, timeout_q;
    logic        op_allow_q, chip_en_n_q, out_en_n_q, write_en_n_q, io_oe_q, ready_busy;
    logic        command_data_strobe_n_q, serial_read_strobe_q, rr_seen, allow = 1'b1;
    logic [7:0]  status_q, io_in, io_out_q;
    logic [11:0] replace_len_q;
    int          err_total = 0, total_checks = 0, seed = 32'he18c, cyc, n;
    fst_host #(.POLL_MAX_CYC(POLL_SIM)) fst_host_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid), .req_op(req_op),
        .req_ready_q(req_ready_q), .done_q(done_q), .status_q(status_q), .fail_q(fail_q),
        .ecc_fix_q(ecc_fix_q), .replace_q(replace_q), .replace_len_q(replace_len_q),
        .reread_q(reread_q), .timeout_q(timeout_q), .op_allow_q(op_allow_q),
        .chip_en_n_q(chip_en_n_q), .out_en_n_q(out_en_n_q), .write_en_n_q(write_en_n_q),
        .command_data_strobe_n_q(command_data_strobe_n_q),
        .serial_read_strobe_q(serial_read_strobe_q), .io_in(io_in), .io_out_q(io_out_q),
        .io_oe_q(io_oe_q), .ready_busy(ready_busy));
    fst_dev_model fst_dev_model_i (
        .ce_n(chip_en_n_q), .oe_n(out_en_n_q), .we_n(write_en_n_q),
        .command_data_strobe_n(command_data_strobe_n_q), .io_out(io_out_q), .io_oe(io_oe_q),
        .io_in(io_in), .ready_busy(ready_busy));
    // *********************
    // checking tasks
    // *********************
    task automatic chk_bit(input logic got, input logic exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask
    task automatic chk_word(input logic [11:0] got, input logic [11:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic do_req(input fst_op_t op);
        cyc = 0;
        rr_seen = 1'b0;
        while (req_ready_q !== 1'b1 && cyc < 50)
        begin
            @(posedge clk_sys);
            #1 cyc++;
        end
        req_valid = 1'b1;
        req_op = op;
        @(posedge clk_sys);
        #1 req_valid = 1'b0;
        cyc = 0;
        while (done_q !== 1'b1 && cyc < 2000)
        begin
            rr_seen |= (reread_q === 1'b1);
            @(posedge clk_sys);
            #1 cyc++;
        end
        rr_seen |= (reread_q === 1'b1);
        chk_bit(done_q, 1'b1, "request done");
        chk_word({6'h00, chip_en_n_q, write_en_n_q, command_data_strobe_n_q, out_en_n_q,
                  io_oe_q, serial_read_strobe_q}, 12'h03C, "idle strobes");
        chk_word({4'h0, io_out_q}, 12'h000, "idle bus");
        chk_bit(req_ready_q, 1'b1, "ready after done");
    endtask
    task automatic poll_chk(input logic [2:0] f);
        logic fl;
        fl = f[1] | f[0];
        allow = allow & ~fl;
        do_req(FST_OP_POLL);
        chk_word({4'h0, status_q}, {4'h0, 1'b1, f, 4'h0}, "status word");
        chk_bit(fail_q, fl, "fail flag");
        chk_bit(ecc_fix_q, fl & f[2], "ecc choice");
        chk_bit(replace_q, fl & ~f[2], "replace choice");
        chk_bit(rr_seen, fl, "reread pulse");
        chk_bit(op_allow_q, allow, "op allow");
        chk_word(replace_len_q, (fl & ~f[2]) ? SECTOR_BYTES : 12'h000, "replace length");
    endtask
    // *********************
    // clock, sequence, watchdog
    // *********************
    initial
    begin
        forever #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
    end
    initial
    begin
        repeat (4) @(posedge clk_sys);
        #1 chk_bit(req_ready_q, 1'b0, "ready in reset");
        chk_bit(op_allow_q, 1'b1, "allow in reset");
        chk_word({4'h0, status_q}, 12'h000, "status in reset");
        rst_n = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            n = {$random(seed)} % 30;
            fst_dev_model_i.flags = i[2:0];
            fst_dev_model_i.busy_until = $realtime + n * CLK_PERIOD_NS;
            poll_chk(i[2:0]);
            poll_chk(i[2:0]);
            do_req(FST_OP_CLEAR);
            allow = 1'b1;
            chk_bit(op_allow_q, 1'b1, "allow after clear");
        end
        poll_chk(3'h0);
        fst_dev_model_i.busy_until = $realtime + 1.0e6;
        do_req(FST_OP_POLL);
        chk_bit(timeout_q, 1'b1, "poll timeout");
        chk_word({4'h0, status_q}, 12'h080, "status kept while busy");
        chk_bit(cyc < POLL_SIM + 40, 1'b1, "timeout bound");
        fst_dev_model_i.busy_until = 0;
        do_req(FST_OP_CLEAR);
        do_req(FST_OP_READ);
        chk_bit(cyc >= RBSY_CYC, 1'b1, "read busy wait");
        chk_bit(timeout_q, 1'b0, "read no timeout");
        give_verdict();
    end
    initial
    begin
        #(20000 * CLK_PERIOD_NS);
        err_total++;
        give_verdict();
    end
endmodule // fst_host_bench
`default_nettype wire
